//--- include/fccr_consts.svh
// register map, field positions, reset values and timing of the fan configuration bank
`ifndef FCCR_CONSTS_SVH
`define FCCR_CONSTS_SVH
`define FCCR_ADDR_FRAC    8'h06
`define FCCR_ADDR_FAN1    8'h20
`define FCCR_ADDR_FAN2    8'h21
`define FCCR_ADDR_SPEED   8'h22
`define FCCR_ADDR_FILTER  8'h23
`define FCCR_RST_FRAC     8'h00
`define FCCR_RST_FAN      8'h5d
`define FCCR_RST_SPEED    8'h55
`define FCCR_RST_FILTER   8'h50
`define FCCR_UNMAPPED     8'h00
`define FCCR_KICK_F       2:0
`define FCCR_FREQ_F       5:3
`define FCCR_RANGE_F      7:6
`define FCCR_SPD1_F       3:0
`define FCCR_SPD2_F       7:4
`define FCCR_KOFF_B       7
`define FCCR_RAMP_F       6:5
`define FCCR_RATE_F       4:2
`define FCCR_FILT2_B      1
`define FCCR_FILT1_B      0
`define FCCR_CLK_HZ       40000000
`define FCCR_MS_PER_S     1000
`define FCCR_PWM_SLOTS    15
`define FCCR_LAST_SLOT    4'he
`define FCCR_KICK_MS      '{32'd200, 32'd400, 32'd600, 32'd800, 32'd1000, 32'd2000, 32'd4000, 32'd8000}
`define FCCR_FREQ_MHZ     '{32'd11700, 32'd15600, 32'd23400, 32'd31250, 32'd37500, 32'd46900, 32'd62500, 32'd93500}
`define FCCR_RAMP_STEP    '{4'h1, 4'h2, 4'h4, 4'h8}
`endif

//--- include/fccr_fan_if.sv
// settings to and status from one fan pwm channel
`timescale 1ns/1ps
`default_nettype none
interface fccr_fan_if;
   logic       en;
   logic       auto_mode;
   logic       kick_off;
   logic [3:0] duty_nib;
   logic [3:0] auto_duty;
   logic [2:0] freq_code;
   logic [2:0] kick_code;
   logic [1:0] ramp_code;
   logic       pwm;
   logic       kicking;
   modport ctl (output en, auto_mode, kick_off, duty_nib, auto_duty, freq_code,
                kick_code, ramp_code, input pwm, kicking);
   modport fan (input en, auto_mode, kick_off, duty_nib, auto_duty, freq_code,
                kick_code, ramp_code, output pwm, kicking);
endinterface
`default_nettype wire

//--- include/fccr_pkg.sv
// types and decode functions of the fan configuration bank
`include "fccr_consts.svh"
package fccr_pkg;
   typedef enum logic [1:0] {FAN_OFF, FAN_KICK, FAN_RUN} fccr_fan_state_t;
   typedef logic [31:0] fccr_count_t;
   typedef fccr_count_t fccr_tab8_t [8];
   typedef logic [3:0] fccr_step_t [4];

   localparam fccr_tab8_t KICK_MS  = `FCCR_KICK_MS;
   localparam fccr_tab8_t FREQ_MHZ = `FCCR_FREQ_MHZ;
   localparam fccr_step_t RAMP     = `FCCR_RAMP_STEP;

   function automatic fccr_count_t fccr_kick_cycles(input logic [2:0] code,
                                                   input fccr_count_t cyc_ms);
      return fccr_count_t'(KICK_MS[code] * cyc_ms);
   endfunction

   // cycles of one of the duty slots making up a pwm period
   function automatic fccr_count_t fccr_slot_cycles(input logic [2:0] code,
                                                   input fccr_count_t cyc_ms);
      logic [63:0] num;
      logic [63:0] res;
      num = 64'(cyc_ms) * 64'd1000000;
      res = num / (64'(FREQ_MHZ[code]) * 64'(`FCCR_PWM_SLOTS));
      return (res == 64'd0) ? 32'd1 : fccr_count_t'(res);
   endfunction

   function automatic logic [3:0] fccr_ramp_step(input logic [1:0] code);
      return RAMP[code];
   endfunction
endpackage

//--- logic/fccr_pwm.sv
// one fan pwm channel with start-up kick and period-aligned updates
`timescale 1ns/1ps
`default_nettype none
`include "fccr_consts.svh"
module fccr_pwm #(
   parameter fccr_pkg::fccr_count_t CYC_PER_MS = 32'd40000
) (
   input  wire logic mclk_in,
   input  wire logic arst_n_in,
   input  wire logic srst_in,
   fccr_fan_if.fan   fan
);
   fccr_pkg::fccr_fan_state_t state_q, state_d;
   fccr_pkg::fccr_count_t     kick_cnt_q, kick_cnt_d, kick_len_q, kick_len_d;
   fccr_pkg::fccr_count_t     slot_cnt_q, slot_cnt_d, slot_len_q, slot_len_d;
   logic [3:0]                slot_idx_q, slot_idx_d, duty_q, duty_d, tgt, step;
   logic [4:0]                up;
   logic                      pwm_q, pwm_d, kick_q, kick_d, slot_end, boundary;

   always_comb begin
      tgt = fan.duty_nib;
      if (fan.auto_mode && (fan.auto_duty > fan.duty_nib)) begin
         tgt = fan.auto_duty;
      end
      step = fccr_pkg::fccr_ramp_step(fan.ramp_code);
      up = {1'b0, duty_q} + {1'b0, step};
      slot_end = (slot_cnt_q >= slot_len_q - 32'd1);
      boundary = slot_end && (slot_idx_q == `FCCR_LAST_SLOT);
      state_d = state_q;
      kick_cnt_d = kick_cnt_q;
      kick_len_d = kick_len_q;
      slot_cnt_d = slot_cnt_q + 32'd1;
      slot_len_d = slot_len_q;
      slot_idx_d = slot_idx_q;
      duty_d = duty_q;
      if (slot_end) begin
         slot_cnt_d = 32'd0;
         slot_idx_d = (slot_idx_q == `FCCR_LAST_SLOT) ? 4'h0 : slot_idx_q + 4'h1;
      end
      if (boundary) begin
         slot_len_d = fccr_pkg::fccr_slot_cycles(fan.freq_code, CYC_PER_MS);
         if (!fan.auto_mode) begin
            duty_d = tgt;
         end else if (tgt > duty_q) begin
            duty_d = (up > {1'b0, tgt}) ? tgt : up[3:0];
         end else begin
            duty_d = ((duty_q - tgt) > step) ? duty_q - step : tgt;
         end
      end
      case (state_q)
         fccr_pkg::FAN_OFF: begin
            slot_cnt_d = 32'd0;
            slot_idx_d = 4'h0;
            if (fan.en) begin
               kick_cnt_d = 32'd0;
               kick_len_d = fccr_pkg::fccr_kick_cycles(fan.kick_code, CYC_PER_MS);
               slot_len_d = fccr_pkg::fccr_slot_cycles(fan.freq_code, CYC_PER_MS);
               duty_d = tgt;
               state_d = fan.kick_off ? fccr_pkg::FAN_RUN : fccr_pkg::FAN_KICK;
            end
         end
         fccr_pkg::FAN_KICK: begin
            kick_cnt_d = kick_cnt_q + 32'd1;
            if (!fan.en) begin
               state_d = fccr_pkg::FAN_OFF;
            end else if (kick_cnt_q >= kick_len_q - 32'd1) begin
               state_d = fccr_pkg::FAN_RUN;
            end
         end
         fccr_pkg::FAN_RUN: begin
            if (!fan.en) begin
               state_d = fccr_pkg::FAN_OFF;
            end
         end
         default: state_d = fccr_pkg::FAN_OFF;
      endcase
      pwm_d = fan.en && ((state_d == fccr_pkg::FAN_KICK) ||
              ((state_d == fccr_pkg::FAN_RUN) && (slot_idx_d < duty_d)));
      if (srst_in) begin
         state_d = fccr_pkg::FAN_OFF;
         duty_d = 4'h0;
         pwm_d = 1'b0;
      end
      kick_d = (state_d == fccr_pkg::FAN_KICK);
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= fccr_pkg::FAN_OFF;
         kick_cnt_q <= 32'd0;
         kick_len_q <= 32'd1;
         slot_cnt_q <= 32'd0;
         slot_len_q <= 32'd1;
         slot_idx_q <= 4'h0;
         duty_q <= 4'h0;
         pwm_q <= 1'b0;
         kick_q <= 1'b0;
      end else begin
         state_q <= state_d;
         kick_cnt_q <= kick_cnt_d;
         kick_len_q <= kick_len_d;
         slot_cnt_q <= slot_cnt_d;
         slot_len_q <= slot_len_d;
         slot_idx_q <= slot_idx_d;
         duty_q <= duty_d;
         pwm_q <= pwm_d;
         kick_q <= kick_d;
      end
   end

   assign fan.pwm = pwm_q;
   assign fan.kicking = kick_q;

   a_kick_entry: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (state_q == fccr_pkg::FAN_OFF && fan.en && !fan.kick_off && !srst_in)
      |=> (state_q == fccr_pkg::FAN_KICK) && pwm_q)
      else $error("fan start did not kick at full duty");
   a_kick_skipped: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (state_q == fccr_pkg::FAN_OFF && fan.en && fan.kick_off && !srst_in)
      |=> (state_q == fccr_pkg::FAN_RUN))
      else $error("kick not skipped while disabled");
   a_kick_full_duty: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (state_q == fccr_pkg::FAN_KICK) |-> pwm_q)
      else $error("pwm low during kick");
   a_kick_length: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (state_q == fccr_pkg::FAN_KICK && fan.en && !srst_in &&
       kick_cnt_q < kick_len_q - 32'd1) |=> (state_q == fccr_pkg::FAN_KICK))
      else $error("kick ended early");
   a_disabled_low: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      !fan.en |=> !pwm_q)
      else $error("pwm driven while disabled");
   a_duty_aligned: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (state_q != fccr_pkg::FAN_OFF && !boundary && !srst_in)
      |=> $stable(duty_q) && $stable(slot_len_q))
      else $error("duty or period changed inside a pwm period");
endmodule // fccr_pwm
`default_nettype wire

//--- logic/fccr_top.sv
// fan configuration register bank with two pwm channels
`timescale 1ns/1ps
`default_nettype none
`include "fccr_consts.svh"
module fccr_top #(
   // cycles per millisecond; lower it to shorten kicks and pwm periods
   parameter fccr_pkg::fccr_count_t CYC_PER_MS = 32'(`FCCR_CLK_HZ / `FCCR_MS_PER_S)
) (
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   input  wire logic       sw_reset_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   input  wire logic [7:0] reg_wdata_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic [2:0] frac_remote1_in,
   input  wire logic [2:0] frac_remote2_in,
   input  wire logic [1:0] frac_local_in,
   input  wire logic       control_source_select_in,
   input  wire logic       pwm1_en_in,
   input  wire logic       pwm2_en_in,
   input  wire logic [3:0] auto_duty1_in,
   input  wire logic [3:0] auto_duty2_in,
   output logic            pwm1_out,
   output logic            pwm2_out,
   output logic            kick1_out,
   output logic            kick2_out,
   output logic      [1:0] speed_range1_out,
   output logic      [1:0] speed_range2_out,
   output logic      [2:0] sample_rate_out,
   output logic            fan1_tach_filter_on_out,
   output logic            fan2_tach_filter_on_out
);
   logic [7:0] frac_q, frac_d;
   logic [7:0] fan1_q, fan1_d;
   logic [7:0] fan2_q, fan2_d;
   logic [7:0] speed_q, speed_d;
   logic [7:0] filter_q, filter_d;
   logic [7:0] rdata_q, rdata_d;

   fccr_fan_if fan1_if ();
   fccr_fan_if fan2_if ();

   // register readback; unmapped addresses read zero
   function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                           input logic [7:0] frac,
                                           input logic [7:0] f1,
                                           input logic [7:0] f2,
                                           input logic [7:0] spd,
                                           input logic [7:0] flt);
      case (addr)
         `FCCR_ADDR_FRAC:   return frac;
         `FCCR_ADDR_FAN1:   return f1;
         `FCCR_ADDR_FAN2:   return f2;
         `FCCR_ADDR_SPEED:  return spd;
         `FCCR_ADDR_FILTER: return flt;
         default:           return `FCCR_UNMAPPED;
      endcase
   endfunction

   always_comb begin
      frac_d = {frac_local_in, frac_remote2_in, frac_remote1_in};
      fan1_d = fan1_q;
      fan2_d = fan2_q;
      speed_d = speed_q;
      filter_d = filter_q;
      rdata_d = rdata_q;
      if (reg_rd_in) begin
         rdata_d = read_mux(reg_addr_in, frac_q, fan1_q, fan2_q, speed_q, filter_q);
      end
      if (sw_reset_in) begin
         fan1_d = `FCCR_RST_FAN;
         fan2_d = `FCCR_RST_FAN;
         speed_d = `FCCR_RST_SPEED;
         filter_d = `FCCR_RST_FILTER;
         frac_d = `FCCR_RST_FRAC;
      end else if (reg_wr_in) begin
         // writes to the fraction register or unmapped addresses are dropped
         case (reg_addr_in)
            `FCCR_ADDR_FAN1:   fan1_d = reg_wdata_in;
            `FCCR_ADDR_FAN2:   fan2_d = reg_wdata_in;
            `FCCR_ADDR_SPEED:  speed_d = reg_wdata_in;
            `FCCR_ADDR_FILTER: filter_d = reg_wdata_in;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         frac_q <= `FCCR_RST_FRAC;
         fan1_q <= `FCCR_RST_FAN;
         fan2_q <= `FCCR_RST_FAN;
         speed_q <= `FCCR_RST_SPEED;
         filter_q <= `FCCR_RST_FILTER;
         rdata_q <= `FCCR_UNMAPPED;
      end else begin
         frac_q <= frac_d;
         fan1_q <= fan1_d;
         fan2_q <= fan2_d;
         speed_q <= speed_d;
         filter_q <= filter_d;
         rdata_q <= rdata_d;
      end
   end

   // channel settings from the register flops; enables, auto mode and auto duty come straight from the input pins
   assign fan1_if.en = pwm1_en_in;
   assign fan1_if.auto_mode = control_source_select_in;
   assign fan1_if.kick_off = filter_q[`FCCR_KOFF_B];
   assign fan1_if.duty_nib = speed_q[`FCCR_SPD1_F];
   assign fan1_if.auto_duty = auto_duty1_in;
   assign fan1_if.freq_code = fan1_q[`FCCR_FREQ_F];
   assign fan1_if.kick_code = fan1_q[`FCCR_KICK_F];
   assign fan1_if.ramp_code = filter_q[`FCCR_RAMP_F];
   assign fan2_if.en = pwm2_en_in;
   assign fan2_if.auto_mode = control_source_select_in;
   assign fan2_if.kick_off = filter_q[`FCCR_KOFF_B];
   assign fan2_if.duty_nib = speed_q[`FCCR_SPD2_F];
   assign fan2_if.auto_duty = auto_duty2_in;
   assign fan2_if.freq_code = fan2_q[`FCCR_FREQ_F];
   assign fan2_if.kick_code = fan2_q[`FCCR_KICK_F];
   assign fan2_if.ramp_code = filter_q[`FCCR_RAMP_F];

   fccr_pwm #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_pwm1 (
      .mclk_in    (mclk_in),
      .arst_n_in  (arst_n_in),
      .srst_in    (sw_reset_in),
      .fan        (fan1_if.fan)
   );

   fccr_pwm #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_pwm2 (
      .mclk_in    (mclk_in),
      .arst_n_in  (arst_n_in),
      .srst_in    (sw_reset_in),
      .fan        (fan2_if.fan)
   );

   assign reg_rdata_out = rdata_q;
   assign pwm1_out = fan1_if.pwm;
   assign pwm2_out = fan2_if.pwm;
   assign kick1_out = fan1_if.kicking;
   assign kick2_out = fan2_if.kicking;
   assign speed_range1_out = fan1_q[`FCCR_RANGE_F];
   assign speed_range2_out = fan2_q[`FCCR_RANGE_F];
   assign sample_rate_out = filter_q[`FCCR_RATE_F];
   assign fan1_tach_filter_on_out = filter_q[`FCCR_FILT1_B];
   assign fan2_tach_filter_on_out = filter_q[`FCCR_FILT2_B];

   a_frac_readback: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_rd_in && reg_addr_in == `FCCR_ADDR_FRAC && !$past(sw_reset_in))
      |=> reg_rdata_out == {$past(frac_local_in, 2), $past(frac_remote2_in, 2),
                            $past(frac_remote1_in, 2)})
      else $error("fraction readback wrong");
   a_frac_read_only: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FRAC && !sw_reset_in)
      |=> frac_q == {$past(frac_local_in), $past(frac_remote2_in), $past(frac_remote1_in)})
      else $error("fraction register took a write");
   a_speed_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_SPEED && !sw_reset_in)
      ##1 (reg_rd_in && reg_addr_in == `FCCR_ADDR_SPEED && !reg_wr_in && !sw_reset_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("speed setting not read back");
   a_sw_defaults: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      sw_reset_in |=> fan1_q == `FCCR_RST_FAN && fan2_q == `FCCR_RST_FAN &&
                      speed_q == `FCCR_RST_SPEED && filter_q == `FCCR_RST_FILTER)
      else $error("software reset left non default settings");
   a_filter_pins: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FILTER && !sw_reset_in)
      |=> fan1_tach_filter_on_out == $past(reg_wdata_in[`FCCR_FILT1_B]) &&
          fan2_tach_filter_on_out == $past(reg_wdata_in[`FCCR_FILT2_B]))
      else $error("filter enables not applied");
   a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_rd_in && reg_addr_in == 8'h07) |=> reg_rdata_out == `FCCR_UNMAPPED)
      else $error("unmapped read not zero");

   // register writes land one cycle after the strobe; read data holds between reads; software reset clears fraction, drops writes
   a_fan1_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FAN1 && !sw_reset_in)
      |=> fan1_q == $past(reg_wdata_in))
      else $error("fan 1 characteristics write lost");
   a_fan2_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FAN2 && !sw_reset_in)
      |=> fan2_q == $past(reg_wdata_in))
      else $error("fan 2 characteristics write lost");
   a_filter_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FILTER && !sw_reset_in)
      |=> filter_q == $past(reg_wdata_in))
      else $error("filter control write lost");
   a_range1_pins: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FAN1 && !sw_reset_in)
      |=> speed_range1_out == $past(reg_wdata_in[`FCCR_RANGE_F]))
      else $error("fan 1 speed range not applied");
   a_range2_pins: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FAN2 && !sw_reset_in)
      |=> speed_range2_out == $past(reg_wdata_in[`FCCR_RANGE_F]))
      else $error("fan 2 speed range not applied");
   a_rate_pins: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (reg_wr_in && reg_addr_in == `FCCR_ADDR_FILTER && !sw_reset_in)
      |=> sample_rate_out == $past(reg_wdata_in[`FCCR_RATE_F]))
      else $error("sample rate not applied");
   a_rdata_stands: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_frac_sw_clear: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      sw_reset_in |=> frac_q == `FCCR_RST_FRAC)
      else $error("fraction register not cleared by software reset");
   a_sw_drops_write: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      (sw_reset_in && reg_wr_in && reg_addr_in == `FCCR_ADDR_SPEED)
      |=> speed_q == `FCCR_RST_SPEED)
      else $error("write taken during software reset");

   // channel outputs as seen at the pins
   a_kick1_high: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      kick1_out |-> pwm1_out)
      else $error("fan 1 pwm low during kick");
   a_kick2_high: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      kick2_out |-> pwm2_out)
      else $error("fan 2 pwm low during kick");
   a_sw_pwm_off: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      sw_reset_in
      |=> !pwm1_out && !pwm2_out && !kick1_out && !kick2_out)
      else $error("channels still active after software reset");
endmodule // fccr_top
`default_nettype wire

//--- verif/fccr_host.sv
// host-side model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module fccr_host (
   input  wire logic       mclk_in,
   input  wire logic [7:0] reg_rdata_in,
   output logic      [7:0] reg_addr_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out,
   output logic      [7:0] reg_wdata_out
);
   initial begin
      reg_addr_out  = 8'h00;
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b0;
      reg_wdata_out = 8'h00;
   end

   // idle lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_out  = a;
      reg_wdata_out = d;
      reg_wr_out    = 1'b1;
      @(negedge mclk_in);
      reg_wr_out    = 1'b0;
      reg_addr_out  = ~a;
      reg_wdata_out = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_rd_out   = 1'b1;
      @(negedge mclk_in);
      reg_rd_out   = 1'b0;
      reg_addr_out = ~a;
      d            = reg_rdata_in;
   endtask

   // write followed by a read of the same register in the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge mclk_in);
      reg_addr_out  = a;
      reg_wdata_out = d;
      reg_wr_out    = 1'b1;
      @(negedge mclk_in);
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b1;
      @(negedge mclk_in);
      reg_rd_out    = 1'b0;
      reg_addr_out  = ~a;
      reg_wdata_out = ~d;
      q             = reg_rdata_in;
   endtask
endmodule // fccr_host
`default_nettype wire

//--- verif/fccr_tb_top.sv
// self-checking bench of the fan configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "fccr_consts.svh"
module fccr_tb_top;
   localparam int CPM  = 10;
   localparam int SLOT = CPM * 1000000 / (93500 * 15);
   localparam int PER  = 15 * SLOT;
   localparam logic [7:0] RA [5] = '{`FCCR_ADDR_FRAC, `FCCR_ADDR_FAN1, `FCCR_ADDR_FAN2,
                                     `FCCR_ADDR_SPEED, `FCCR_ADDR_FILTER};
   localparam logic [7:0] RV [5] = '{`FCCR_RST_FRAC, `FCCR_RST_FAN, `FCCR_RST_FAN,
                                     `FCCR_RST_SPEED, `FCCR_RST_FILTER};
   localparam logic [7:0] WV [5] = '{8'hd5, 8'h38, 8'h38, 8'ha5, 8'h5f};
   logic       mclk_in;
   logic       arst_n_in;
   logic       sw_reset_in;
   logic [7:0] addr, wdata, rdata, v;
   logic       wr, rd, sel, en1, en2;
   logic [2:0] fr1, fr2, srate;
   logic [1:0] frl, rng1, rng2;
   logic [3:0] ad1, ad2;
   logic       pwm1, pwm2, kick1, kick2, filt1, filt2;
   int         mismatches, compares, cycles, c1, c2;

   fccr_host i_fccr_host (.mclk_in(mclk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));

   fccr_top #(.CYC_PER_MS(CPM)) i_fccr_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .sw_reset_in(sw_reset_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .frac_remote1_in(fr1),
      .frac_remote2_in(fr2), .frac_local_in(frl), .control_source_select_in(sel),
      .pwm1_en_in(en1), .pwm2_en_in(en2), .auto_duty1_in(ad1), .auto_duty2_in(ad2),
      .pwm1_out(pwm1), .pwm2_out(pwm2), .kick1_out(kick1), .kick2_out(kick2),
      .speed_range1_out(rng1), .speed_range2_out(rng2), .sample_rate_out(srate),
      .fan1_tach_filter_on_out(filt1), .fan2_tach_filter_on_out(filt2));

   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp, input string m);
      compares++;
      if (got != exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      i_fccr_host.rd(a, v);
      chk(v, e, m);
   endtask

   // high cycles of both pwm outputs over n cycles
   task automatic count_hi(input int n);
      c1 = 0;
      c2 = 0;
      repeat (n) begin
         @(negedge mclk_in);
         if (pwm1 === 1'b1) c1++;
         if (pwm2 === 1'b1) c2++;
      end
   endtask

   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         conclude();
      end
   end

   initial begin
      {arst_n_in, sw_reset_in, sel, en1, en2} = 5'h00;
      {fr1, fr2, frl, ad1, ad2} = 16'h0000;
      mismatches = 0;
      compares = 0;
      cycles = 0;
      repeat (3) @(negedge mclk_in);
      arst_n_in = 1'b1;
      for (int i = 0; i < 5; i++) rdc(RA[i], RV[i], "reset value");
      rdc(8'h07, `FCCR_UNMAPPED, "unmapped read");
      chk({rng2, rng1, 1'b0, srate}, 8'h54, "reset outputs");
      chk({6'h00, filt2, filt1}, 8'h00, "reset filters");
      $display("test reset done");

      for (int i = 0; i < 5; i++) i_fccr_host.wr(RA[i], WV[i] ^ 8'h00);
      i_fccr_host.wr(`FCCR_ADDR_FRAC, 8'h2a);
      fr1 = 3'h5;
      fr2 = 3'h2;
      frl = 2'h3;
      for (int i = 0; i < 5; i++) rdc(RA[i], WV[i], "readback");
      i_fccr_host.wr_rd(`FCCR_ADDR_SPEED, WV[3], v);
      chk(v, WV[3], "write then read");
      chk({rng2, rng1, 1'b0, srate}, 8'h07, "field outputs");
      chk({6'h00, filt2, filt1}, 8'h03, "filter outputs");
      $display("test registers done");

      en1 = 1'b1;
      en2 = 1'b1;
      @(negedge mclk_in);
      chk({4'h0, kick2, kick1, pwm2, pwm1}, 8'h0f, "kick start");
      c1 = 0;
      c2 = 0;
      for (int i = 0; i < 3000 && (kick1 !== 1'b0 || kick2 !== 1'b0); i++) begin
         if (kick1 === 1'b1) c1++;
         if (kick2 === 1'b1) c2++;
         @(negedge mclk_in);
      end
      chk_n(c1, 200 * CPM, "kick1 length");
      chk_n(c2, 200 * CPM, "kick2 length");
      $display("test kick done");

      repeat (3 * PER) @(negedge mclk_in);
      count_hi(PER);
      chk_n(c1, 5 * SLOT, "fan1 software duty");
      chk_n(c2, 10 * SLOT, "fan2 software duty");
      sel = 1'b1;
      ad1 = 4'hf;
      repeat (10 * PER) @(negedge mclk_in);
      count_hi(PER);
      chk_n(c1, PER, "fan1 auto duty");
      chk_n(c2, 10 * SLOT, "fan2 minimum duty");
      $display("test duty done");

      en1 = 1'b0;
      en2 = 1'b0;
      @(negedge mclk_in);
      count_hi(PER);
      chk_n(c1 + c2, 0, "disabled outputs");
      i_fccr_host.wr(`FCCR_ADDR_FILTER, 8'hdf);
      en1 = 1'b1;
      c1 = 0;
      repeat (2 * PER) begin
         @(negedge mclk_in);
         if (kick1 !== 1'b0) c1++;
      end
      chk_n(c1, 0, "kick skipped");
      $display("test enable done");

      @(negedge mclk_in);
      sw_reset_in = 1'b1;
      i_fccr_host.wr(`FCCR_ADDR_SPEED, 8'h00);
      sw_reset_in = 1'b0;
      for (int i = 1; i < 5; i++) rdc(RA[i], RV[i], "soft reset");
      $display("test soft reset done");
      conclude();
   end
endmodule // fccr_tb_top
`default_nettype wire
